// ===== hdl/interval_timer.sv
`timescale 1ns/1ns
module interval_timer #(
  parameter int W = 20
) (
  // clock and reset
  input wire logic i_clk,
  input wire logic i_rstn,
  // control
  input wire logic i_restart,
  input wire logic [W-1:0] i_period,
  // tick out
  output logic o_tick
);
  logic [W-1:0] cnt_q;
  logic [W-1:0] cnt_d;
  logic tick_d;

  // reload on restart or expiry, tick once per period
  always_comb begin
    cnt_d = cnt_q - W'(1);
    tick_d = 1'b0;
    if (i_restart) begin
      cnt_d = i_period - W'(1);
    end else if (cnt_q == '0) begin
      cnt_d = i_period - W'(1);
      tick_d = 1'b1;
    end
  end

  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      cnt_q <= '0;
      o_tick <= 1'b0;
    end else begin
      cnt_q <= cnt_d;
      o_tick <= tick_d;
    end
  end
endmodule

// ===== hdl/mod_clock_gen.sv
`timescale 1ns/1ns
`include "rec_map.svh"
module mod_clock_gen #(
  parameter int DIV = `REC_SAMPLE_DIV
) (
  // clock and reset
  input wire logic i_clk,
  input wire logic i_rstn,
  // selection
  input wire logic i_quarter,
  // converter timing
  output logic o_mod_clk_en,
  output logic o_sample_strobe,
  output logic o_filter_alt
);
  localparam int CW = $clog2(DIV);
  logic [CW-1:0] cnt_q;
  logic [CW-1:0] cnt_d;
  logic quarter_q;
  logic quarter_d;
  logic mod_d;
  logic strobe_d;

  if (DIV < 4 || (DIV % 4) != 0) begin : g_chk
    $error("DIV must be a multiple of 4");
  end

  // divider; selection changes only at a sample boundary
  always_comb begin
    cnt_d = cnt_q + CW'(1);
    strobe_d = (cnt_q == CW'(DIV - 1));
    quarter_d = strobe_d ? i_quarter : quarter_q;
    mod_d = quarter_q ? (cnt_q[1:0] == 2'h3) : cnt_q[0];
  end

  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      cnt_q <= '0;
      quarter_q <= 1'b0;
      o_mod_clk_en <= 1'b0;
      o_sample_strobe <= 1'b0;
      o_filter_alt <= 1'b0;
    end else begin
      cnt_q <= cnt_d;
      quarter_q <= quarter_d;
      o_mod_clk_en <= mod_d; // R11
      o_sample_strobe <= strobe_d; // R10
      o_filter_alt <= quarter_q; // R13
    end
  end

  property p_rate;
    @(posedge i_clk) disable iff (!i_rstn)
      o_sample_strobe |-> ##256 o_sample_strobe;
  endproperty
  a_rate: assert property (p_rate) else $error("sample strobe not every 256"); // R10

  property p_half;
    @(posedge i_clk) disable iff (!i_rstn)
      (!o_filter_alt && o_mod_clk_en && $stable(o_filter_alt)) |=> !o_mod_clk_en;
  endproperty
  a_half: assert property (p_half) else $error("modulator enable not half rate"); // R11
endmodule

// ===== hdl/record_gain_level_control.sv
`timescale 1ns/1ns
`include "rec_map.svh"
// Overview of operation
// [R1] normal recovery raises gain only while no attack is in progress
// [R2] below recovery threshold and not attacking: gain rises one 0.5 dB step
// [R3] one recovery step per recovery interval until programmed gain is reached
// [R4] output above recovery threshold holds gain until it falls back
// [R5] restored gain stays put until a new attack starts
// [R6] limited mode attacks on excursion then tries to restore gain
// [R7] limited mode counts recovery intervals that saw a recovery excursion
// [R8] counter at configured maximum settles gain, no more recovery
// [R9] attack excursion restarts attack and clears the excursion counter
// [R10] output sample rate is master clock divided by 256
// [R11] modulator runs at half master clock by default
// [R12] software sets quarter clock when master clock exceeds 12.288 MHz
// [R13] quarter clock selects the alternate decimator filter set
// [R14] attack lowers both gains one step, then waits the attack time
// [R15] gains never exceed their programmed values
// [R16] gain and level settings ignore writes while level control enabled
// [R17] limit bit 1 needs both channels over threshold, 0 needs either
// [R18] recovery steps both gains equally, decided only at interval ticks
module record_gain_level_control
  import rec_pkg::*;
#(
  parameter int SMP_W = 24,
  parameter int TMR_W = 20,
  parameter int ATTACK_UNIT_CYC = `REC_ATTACK_UNIT,
  parameter int RECOV_UNIT_CYC = `REC_RECOV_UNIT
) (
  // clock and reset
  input wire logic i_clk,
  input wire logic i_rstn,
  // apb slave
  input wire logic i_psel,
  input wire logic i_penable,
  input wire logic i_pwrite,
  input wire logic [7:0] i_paddr,
  input wire logic [31:0] i_pwdata,
  output logic o_pready,
  output logic [31:0] o_prdata,
  output logic o_pslverr,
  // converter output samples
  input wire logic i_smp_valid,
  input wire logic [SMP_W-1:0] i_smp_left,
  input wire logic [SMP_W-1:0] i_smp_right,
  // amplifier and converter control
  output logic [5:0] o_pga_gain_left,
  output logic [5:0] o_pga_gain_right,
  output logic o_mod_clk_en,
  output logic o_sample_strobe,
  output logic o_filter_alt
);
  if (SMP_W < 9 || 16 * ATTACK_UNIT_CYC >= (1 << TMR_W)
      || 16 * RECOV_UNIT_CYC >= (1 << TMR_W)) begin : g_chk
    $error("sample width or timer units out of range");
  end

  // magnitude of a sample, top 8 bits below the sign, above a threshold
  function automatic logic over_thr(input logic [SMP_W-1:0] s, input logic [7:0] thr);
    logic [SMP_W-1:0] mag;
    mag = s[SMP_W-1] ? (~s + SMP_W'(1)) : s;
    if (mag[SMP_W-1]) begin
      over_thr = 1'b1;
    end else begin
      over_thr = mag[SMP_W-2 -: 8] > thr;
    end
  endfunction

  // programmed gain reduced by the common attenuation, floored at zero
  function automatic gain_t sat_sub(input gain_t g, input gain_t a);
    sat_sub = (g > a) ? (g - a) : '0;
  endfunction

  // clip a written gain code to the amplifier range
  function automatic gain_t clip_gain(input logic [5:0] g);
    clip_gain = (g > `REC_GAIN_MAX) ? `REC_GAIN_MAX : g;
  endfunction

  // register state
  logic pready_q, pready_d;
  logic [31:0] prdata_q, prdata_d;
  logic pslverr_q, pslverr_d;
  logic [7:0] ctrl1_q, ctrl1_d;
  logic [15:0] ctrl2_q, ctrl2_d;
  logic [7:0] ctrl3_q, ctrl3_d;
  gain_t gain_l_q, gain_l_d;
  gain_t gain_r_q, gain_r_d;
  logic quarter_q, quarter_d;
  logic alc_restart;

  // level controller state
  alc_state_e state_q, state_d;
  gain_t att_q, att_d;
  logic [3:0] cnt_q, cnt_d;
  logic exc_q, exc_d;
  gain_t out_l_q, out_l_d;
  gain_t out_r_q, out_r_d;
  logic atk_start;

  logic acc;
  logic wr;
  logic hit;
  logic [31:0] rd_mux;
  logic alc_en;
  logic atk_l, atk_r, atk_hit, rec_hit, exc_now;
  logic atk_tick, rec_tick;
  logic [1:0] mode;
  logic [3:0] ex_max;
  logic [TMR_W-1:0] atk_period, rec_period;

  assign acc = i_psel & i_penable & pready_q;
  assign wr = acc & i_pwrite;
  assign alc_en = ctrl1_q[`REC_EN_BIT];
  assign mode = ctrl1_q[`REC_MODE_LSB +: 2];
  assign ex_max = ctrl1_q[`REC_EXMAX_LSB +: 4];

  // address decode and read data
  always_comb begin
    hit = 1'b1;
    rd_mux = 32'h00000000;
    unique case (i_paddr)
      `REC_CTRL1_OFS: rd_mux = {24'h000000, ctrl1_q};
      `REC_CTRL2_OFS: rd_mux = {16'h0000, ctrl2_q};
      `REC_CTRL3_OFS: rd_mux = {24'h000000, ctrl3_q};
      `REC_GAIN_L_OFS: rd_mux = {26'h0, gain_l_q};
      `REC_GAIN_R_OFS: rd_mux = {26'h0, gain_r_q};
      `REC_ADC_CTRL_OFS: rd_mux = {31'h0, quarter_q};
      `REC_STATUS_OFS: begin
        rd_mux[`REC_ST_GL_LSB +: 6] = out_l_q;
        rd_mux[`REC_ST_GR_LSB +: 6] = out_r_q;
        rd_mux[`REC_ST_CNT_LSB +: 4] = cnt_q;
        rd_mux[`REC_ST_STATE_LSB +: 2] = state_q;
        rd_mux[`REC_ST_ATT_LSB +: 6] = att_q;
      end
      default: hit = 1'b0;
    endcase
  end

  // apb answer one cycle into the access phase, error on unmapped address
  always_comb begin
    pready_d = i_psel & i_penable & ~pready_q;
    prdata_d = prdata_q;
    pslverr_d = 1'b0;
    if (pready_d) begin
      prdata_d = i_pwrite ? 32'h00000000 : rd_mux;
      pslverr_d = ~hit;
    end
  end

  // register writes; gain and level settings frozen while the controller is enabled, enable bit and adc control stay writable
  always_comb begin
    ctrl1_d = ctrl1_q;
    ctrl2_d = ctrl2_q;
    ctrl3_d = ctrl3_q;
    gain_l_d = gain_l_q;
    gain_r_d = gain_r_q;
    quarter_d = quarter_q;
    alc_restart = 1'b0;
    if (wr) begin
      unique case (i_paddr)
        `REC_CTRL1_OFS: begin
          if (alc_en) begin
            ctrl1_d[`REC_EN_BIT] = i_pwdata[`REC_EN_BIT]; // R16
          end else begin
            ctrl1_d = i_pwdata[7:0];
          end
        end
        `REC_CTRL2_OFS: if (!alc_en) ctrl2_d = i_pwdata[15:0]; // R16
        `REC_CTRL3_OFS: begin
          alc_restart = 1'b1;
          if (!alc_en) ctrl3_d = i_pwdata[7:0]; // R16
        end
        `REC_GAIN_L_OFS: if (!alc_en) gain_l_d = clip_gain(i_pwdata[5:0]); // R16
        `REC_GAIN_R_OFS: if (!alc_en) gain_r_d = clip_gain(i_pwdata[5:0]); // R16
        `REC_ADC_CTRL_OFS: quarter_d = i_pwdata[`REC_QUARTER_BIT];
        default: ;
      endcase
    end
  end

  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      pready_q <= 1'b0;
      prdata_q <= 32'h00000000;
      pslverr_q <= 1'b0;
      ctrl1_q <= `REC_CTRL1_RST;
      ctrl2_q <= `REC_CTRL2_RST;
      ctrl3_q <= `REC_CTRL3_RST;
      gain_l_q <= `REC_GAIN_RST;
      gain_r_q <= `REC_GAIN_RST;
      quarter_q <= 1'b0;
    end else begin
      pready_q <= pready_d;
      prdata_q <= prdata_d;
      pslverr_q <= pslverr_d;
      ctrl1_q <= ctrl1_d;
      ctrl2_q <= ctrl2_d;
      ctrl3_q <= ctrl3_d;
      gain_l_q <= gain_l_d;
      gain_r_q <= gain_r_d;
      quarter_q <= quarter_d;
    end
  end

  assign o_pready = pready_q;
  assign o_prdata = prdata_q;
  assign o_pslverr = pslverr_q;

  // threshold checks on each converter sample
  always_comb begin
    atk_l = over_thr(i_smp_left, ctrl2_q[`REC_ATHR_LSB +: 8]);
    atk_r = over_thr(i_smp_right, ctrl2_q[`REC_ATHR_LSB +: 8]);
    atk_hit = i_smp_valid & (ctrl1_q[`REC_BOTH_BIT] ? (atk_l & atk_r) : (atk_l | atk_r)); // R17
    rec_hit = i_smp_valid & (over_thr(i_smp_left, ctrl2_q[`REC_RTHR_LSB +: 8])
      | over_thr(i_smp_right, ctrl2_q[`REC_RTHR_LSB +: 8]));
    exc_now = exc_q | rec_hit;
  end

  // timer periods from control 3
  assign atk_period = TMR_W'((ctrl3_q[`REC_ATIM_LSB +: 4] + 5'h01) * ATTACK_UNIT_CYC);
  assign rec_period = TMR_W'((ctrl3_q[`REC_RTIM_LSB +: 4] + 5'h01) * RECOV_UNIT_CYC);

  interval_timer #(.W(TMR_W)) u_atk_tmr (
    .i_clk(i_clk),
    .i_rstn(i_rstn),
    .i_restart(atk_start),
    .i_period(atk_period),
    .o_tick(atk_tick)
  );

  interval_timer #(.W(TMR_W)) u_rec_tmr (
    .i_clk(i_clk),
    .i_rstn(i_rstn),
    .i_restart(atk_start | ~alc_en),
    .i_period(rec_period),
    .o_tick(rec_tick)
  );

  // attack, recovery and excursion counting
  always_comb begin
    state_d = state_q;
    att_d = att_q;
    cnt_d = cnt_q;
    exc_d = rec_hit | (exc_q & ~rec_tick);
    atk_start = 1'b0;
    if (!alc_en || alc_restart) begin
      state_d = alc_en ? ALC_TRACK : ALC_OFF;
      att_d = '0;
      cnt_d = 4'h0;
      exc_d = 1'b0;
    end else begin
      unique case (state_q)
        ALC_OFF: state_d = ALC_TRACK;
        ALC_TRACK, ALC_SETTLED: begin
          if (atk_hit) begin
            atk_start = 1'b1; // R6
            state_d = ALC_ATTACK;
            cnt_d = 4'h0; // R9
            exc_d = 1'b0;
            if (att_q < `REC_GAIN_MAX) att_d = att_q + 6'h01; // R14
          end else if (state_q == ALC_TRACK && rec_tick) begin // R18
            if (mode == `REC_MODE_NORMAL) begin
              if (!exc_now && att_q != '0) att_d = att_q - 6'h01; // R1 R2 R3 R4 R5
            end else if (mode == `REC_MODE_LIMITED) begin
              if (exc_now) begin
                cnt_d = cnt_q + 4'h1; // R7
                if (cnt_q + 4'h1 >= ex_max) state_d = ALC_SETTLED; // R8
              end else if (att_q != '0) begin
                att_d = att_q - 6'h01; // R6
              end
            end
          end
        end
        ALC_ATTACK: if (atk_tick) state_d = ALC_TRACK; // R14
      endcase
    end
    out_l_d = sat_sub(gain_l_d, att_d); // R15 R18
    out_r_d = sat_sub(gain_r_d, att_d); // R15 R18
  end

  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      state_q <= ALC_OFF;
      att_q <= '0;
      cnt_q <= 4'h0;
      exc_q <= 1'b0;
      out_l_q <= '0;
      out_r_q <= '0;
    end else begin
      state_q <= state_d;
      att_q <= att_d;
      cnt_q <= cnt_d;
      exc_q <= exc_d;
      out_l_q <= out_l_d;
      out_r_q <= out_r_d;
    end
  end

  assign o_pga_gain_left = out_l_q;
  assign o_pga_gain_right = out_r_q;

  // modulator clock and sample timing
  mod_clock_gen #(.DIV(`REC_SAMPLE_DIV)) u_clk_gen (
    .i_clk(i_clk),
    .i_rstn(i_rstn),
    .i_quarter(quarter_q), // R12
    .o_mod_clk_en(o_mod_clk_en),
    .o_sample_strobe(o_sample_strobe),
    .o_filter_alt(o_filter_alt)
  );

  property p_ceiling;
    @(posedge i_clk) disable iff (!i_rstn)
      o_pga_gain_left <= gain_l_q && o_pga_gain_right <= gain_r_q;
  endproperty
  a_ceiling: assert property (p_ceiling) else $error("gain above programmed value"); // R15

  property p_attack;
    @(posedge i_clk) disable iff (!i_rstn)
      (alc_en && !alc_restart && state_q == ALC_TRACK && atk_hit && att_q < 6'h30)
      |=> state_q == ALC_ATTACK && att_q == $past(att_q) + 6'h01;
  endproperty
  a_attack: assert property (p_attack) else $error("attack step missing"); // R14

  property p_wait;
    @(posedge i_clk) disable iff (!i_rstn)
      (state_q == ALC_ATTACK && alc_en && !alc_restart) |=> att_q == $past(att_q);
  endproperty
  a_wait: assert property (p_wait) else $error("gain changed during attack wait"); // R14

  property p_recover;
    @(posedge i_clk) disable iff (!i_rstn)
      (alc_en && !alc_restart && state_q == ALC_TRACK && !atk_hit && rec_tick
       && mode == `REC_MODE_NORMAL && !exc_now && att_q != 6'h00)
      |=> att_q == $past(att_q) - 6'h01;
  endproperty
  a_recover: assert property (p_recover) else $error("recovery step missing"); // R2

  property p_hold;
    @(posedge i_clk) disable iff (!i_rstn)
      (alc_en && !alc_restart && !atk_hit && (exc_now || !rec_tick)) |=> att_q >= $past(att_q);
  endproperty
  a_hold: assert property (p_hold) else $error("gain raised without a clean tick"); // R4

  property p_restored;
    @(posedge i_clk) disable iff (!i_rstn)
      (alc_en && !alc_restart && att_q == 6'h00 && !atk_hit) |=> att_q == 6'h00;
  endproperty
  a_restored: assert property (p_restored) else $error("restored gain changed"); // R5

  property p_count;
    @(posedge i_clk) disable iff (!i_rstn)
      (alc_en && !alc_restart && state_q == ALC_TRACK && !atk_hit && rec_tick
       && mode == `REC_MODE_LIMITED && exc_now) |=> cnt_q == $past(cnt_q) + 4'h1;
  endproperty
  a_count: assert property (p_count) else $error("excursion count missed"); // R7

  property p_settle;
    @(posedge i_clk) disable iff (!i_rstn)
      (state_q == ALC_SETTLED && alc_en && !alc_restart && !atk_hit)
      |=> state_q == ALC_SETTLED && att_q == $past(att_q);
  endproperty
  a_settle: assert property (p_settle) else $error("recovery after settling"); // R8

  property p_clear;
    @(posedge i_clk) disable iff (!i_rstn)
      (alc_en && (state_q == ALC_TRACK || state_q == ALC_SETTLED) && atk_hit)
      |=> cnt_q == 4'h0;
  endproperty
  a_clear: assert property (p_clear) else $error("counter not cleared by attack"); // R9

  property p_frozen;
    @(posedge i_clk) disable iff (!i_rstn)
      (wr && alc_en && i_paddr == `REC_GAIN_L_OFS) |=> gain_l_q == $past(gain_l_q);
  endproperty
  a_frozen: assert property (p_frozen) else $error("gain written while enabled"); // R16

  property p_both;
    @(posedge i_clk) disable iff (!i_rstn)
      (ctrl1_q[`REC_BOTH_BIT] && !(atk_l && atk_r)) |-> !atk_hit;
  endproperty
  a_both: assert property (p_both) else $error("single channel caused attack"); // R17
endmodule

// ===== shared/rec_map.svh
`ifndef REC_MAP_SVH
`define REC_MAP_SVH

// register byte offsets
`define REC_CTRL1_OFS 8'h00
`define REC_CTRL2_OFS 8'h04
`define REC_CTRL3_OFS 8'h08
`define REC_GAIN_L_OFS 8'h0C
`define REC_GAIN_R_OFS 8'h10
`define REC_ADC_CTRL_OFS 8'h14
`define REC_STATUS_OFS 8'h18

// control 1 fields
`define REC_EN_BIT 0
`define REC_BOTH_BIT 1
`define REC_MODE_LSB 2
`define REC_EXMAX_LSB 4
// control 2 fields
`define REC_ATHR_LSB 0
`define REC_RTHR_LSB 8
// control 3 fields
`define REC_ATIM_LSB 0
`define REC_RTIM_LSB 4
// adc control field
`define REC_QUARTER_BIT 0
// status fields
`define REC_ST_GL_LSB 0
`define REC_ST_GR_LSB 8
`define REC_ST_CNT_LSB 16
`define REC_ST_STATE_LSB 20
`define REC_ST_ATT_LSB 24

// recovery mode codes
`define REC_MODE_NONE 2'h0
`define REC_MODE_NORMAL 2'h1
`define REC_MODE_LIMITED 2'h2

// reset values
`define REC_CTRL1_RST 8'h00
`define REC_CTRL2_RST 16'h0000
`define REC_CTRL3_RST 8'h00
`define REC_GAIN_RST 6'h00

// gain code limit: 24 dB in 0.5 dB steps
`define REC_GAIN_MAX 6'h30
// master clock cycles per output sample
`define REC_SAMPLE_DIV 256
// default timer units in clock cycles
`define REC_ATTACK_UNIT 256
`define REC_RECOV_UNIT 2048

`endif

// ===== shared/rec_pkg.sv
package rec_pkg;
  typedef enum logic [1:0] {
    ALC_OFF,
    ALC_TRACK,
    ALC_ATTACK,
    ALC_SETTLED
  } alc_state_e;

  typedef logic [5:0] gain_t;
endpackage

// ===== tb/rec_partner.sv
`timescale 1ns/1ns
module rec_partner #(
  parameter int SMP_W = 24
) (
  // clock and reset
  input wire logic i_clk,
  input wire logic i_rstn,
  // amplifier gains and scenario input levels
  input wire logic [5:0] i_gain_left,
  input wire logic [5:0] i_gain_right,
  input wire logic [7:0] i_base_left,
  input wire logic [7:0] i_base_right,
  // converter output samples
  output logic o_smp_valid,
  output logic [SMP_W-1:0] o_smp_left,
  output logic [SMP_W-1:0] o_smp_right
);
  logic [1:0] div_q;
  logic [SMP_W-1:0] lvl_l;
  logic [SMP_W-1:0] lvl_r;
  // output level rises one threshold unit per gain step
  assign lvl_l = SMP_W'(i_base_left + 8'(i_gain_left)) << (SMP_W - 9);
  assign lvl_r = SMP_W'(i_base_right + 8'(i_gain_right)) << (SMP_W - 9);
  // one sample every 4 cycles, right channel negative, lines toggle between samples
  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      div_q <= 2'h0;
      o_smp_valid <= 1'b0;
      o_smp_left <= '0;
      o_smp_right <= '0;
    end else begin
      div_q <= div_q + 2'h1;
      o_smp_valid <= (div_q == 2'h3);
      o_smp_left <= (div_q == 2'h3) ? lvl_l : ~o_smp_left;
      o_smp_right <= (div_q == 2'h3) ? -lvl_r : ~o_smp_right;
    end
  end
endmodule

// ===== tb/record_gain_level_control_tb.sv
`timescale 1ns/1ns
`include "rec_map.svh"
module record_gain_level_control_tb;
  logic clk, rstn, psel, penable, pwrite, pready, pslverr, over_seen;
  logic [7:0] paddr, base_l, base_r;
  logic [31:0] pwdata, prdata;
  logic smp_valid, mod_en, strobe, falt;
  logic [23:0] smp_l, smp_r;
  logic [5:0] gl, gr;
  int error_cnt, n_checks;

  record_gain_level_control #(.ATTACK_UNIT_CYC(4), .RECOV_UNIT_CYC(8)) uut (
    .i_clk(clk), .i_rstn(rstn), .i_psel(psel), .i_penable(penable), .i_pwrite(pwrite),
    .i_paddr(paddr), .i_pwdata(pwdata), .o_pready(pready), .o_prdata(prdata),
    .o_pslverr(pslverr), .i_smp_valid(smp_valid), .i_smp_left(smp_l), .i_smp_right(smp_r),
    .o_pga_gain_left(gl), .o_pga_gain_right(gr), .o_mod_clk_en(mod_en),
    .o_sample_strobe(strobe), .o_filter_alt(falt));

  rec_partner partner (
    .i_clk(clk), .i_rstn(rstn), .i_gain_left(gl), .i_gain_right(gr), .i_base_left(base_l),
    .i_base_right(base_r), .o_smp_valid(smp_valid), .o_smp_left(smp_l), .o_smp_right(smp_r));

  // clock at 10 MHz
  always #50 clk = ~clk;

  // remember any gain above its programmed value
  always @(posedge clk) begin
    if (gl > 6'h14 || gr > 6'h10) begin
      over_seen <= 1'b1;
    end
  end

  task automatic end_of_test();
    $display("checks %0d errors %0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  task automatic check(input string name, input logic [31:0] exp, input logic [31:0] got);
    n_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("[FAIL] %s expected %h seen %h", name, exp, got);
    end
  endtask

  // one apb transfer, waits for pready with a bounded count
  task automatic apb_xfer(input logic [7:0] a, input logic w, input logic [31:0] d,
                          output logic [31:0] r, output logic e);
    int k;
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    k = 0;
    do begin
      @(posedge clk);
      k++;
    end while (pready !== 1'b1 && k < 50);
    if (pready !== 1'b1) begin
      error_cnt++;
      $display("[FAIL] pready expected 1 seen %b", pready);
    end
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic apb_w(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    logic e;
    apb_xfer(a, 1'b1, d, r, e);
  endtask

  task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp, input string name);
    logic [31:0] r;
    logic e;
    apb_xfer(a, 1'b0, 32'h0, r, e);
    check(name, exp, r);
  endtask

  task automatic chk_gain(input logic [5:0] l, input logic [5:0] r);
    check("gain_left", {26'h0, l}, {26'h0, gl});
    check("gain_right", {26'h0, r}, {26'h0, gr});
  endtask

  // cycles between two pulses of the strobe (s=0) or modulator enable (s=1)
  task automatic period(input logic s, output int n);
    int k;
    k = 0;
    do begin
      @(posedge clk);
      k++;
    end while ((s ? mod_en : strobe) !== 1'b1 && k < 600);
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while ((s ? mod_en : strobe) !== 1'b1 && n < 600);
  endtask

  task automatic idle(input int n);
    repeat (n) @(posedge clk);
  endtask

  initial begin
    logic [31:0] r;
    logic e;
    int n;
    clk = 1'b0;
    rstn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    base_l = 8'h00;
    base_r = 8'h00;
    over_seen = 1'b0;
    error_cnt = 0;
    n_checks = 0;
    idle(2);
    rstn <= 1'b1;
    @(posedge clk);
    chk_gain(6'h00, 6'h00);
    rd_chk(`REC_STATUS_OFS, 32'h0, "status_reset");
    apb_xfer(8'h1C, 1'b0, 32'h0, r, e);
    check("unmapped_err", 32'h1, {31'h0, e});
    // sample and modulator rates, default then quarter clock
    period(1'b0, n);
    check("strobe_period", 32'h100, 32'(n));
    period(1'b1, n);
    check("mod_period", 32'h2, 32'(n));
    check("filter_alt_dflt", 32'h0, {31'h0, falt});
    apb_w(`REC_ADC_CTRL_OFS, 32'h1);
    idle(600);
    period(1'b0, n);
    check("strobe_period_q", 32'h100, 32'(n));
    period(1'b1, n);
    check("mod_period_q", 32'h4, 32'(n));
    check("filter_alt", 32'h1, {31'h0, falt});
    apb_w(`REC_ADC_CTRL_OFS, 32'h0);
    // normal recovery, either channel triggers attack
    base_l <= 8'h1E;
    apb_w(`REC_GAIN_L_OFS, 32'h14);
    apb_w(`REC_GAIN_R_OFS, 32'h10);
    apb_w(`REC_CTRL2_OFS, 32'h1E28);
    apb_w(`REC_CTRL3_OFS, 32'h0);
    apb_w(`REC_CTRL1_OFS, 32'h5);
    idle(1500);
    chk_gain(6'h0A, 6'h06);
    apb_w(`REC_GAIN_L_OFS, 32'h05);
    rd_chk(`REC_GAIN_L_OFS, 32'h14, "gain_locked");
    base_l <= 8'h00;
    idle(1500);
    chk_gain(6'h14, 6'h10);
    // both channels must exceed the attack threshold
    apb_w(`REC_CTRL1_OFS, 32'h0);
    apb_w(`REC_CTRL1_OFS, 32'h7);
    base_l <= 8'h1E;
    idle(1000);
    chk_gain(6'h14, 6'h10);
    base_r <= 8'h1E;
    idle(1500);
    chk_gain(6'h0E, 6'h0A);
    // limited recovery with excursion maximum of 2
    base_l <= 8'h00;
    base_r <= 8'h00;
    apb_w(`REC_CTRL1_OFS, 32'h0);
    apb_w(`REC_CTRL1_OFS, 32'h28);
    apb_w(`REC_CTRL1_OFS, 32'h29);
    base_l <= 8'h1E;
    idle(1500);
    chk_gain(6'h0A, 6'h06);
    rd_chk(`REC_STATUS_OFS, 32'h0A32060A, "status_settled");
    base_l <= 8'h00;
    idle(1500);
    chk_gain(6'h0A, 6'h06);
    base_l <= 8'h3C;
    idle(100);
    base_l <= 8'h00;
    idle(2000);
    chk_gain(6'h14, 6'h10);
    rd_chk(`REC_STATUS_OFS, 32'h00101014, "status_restored");
    check("gain_ceiling", 32'h0, {31'h0, over_seen});
    end_of_test();
  end

  // watchdog against a hung handshake
  initial begin
    idle(40000);
    error_cnt++;
    $display("[FAIL] watchdog expected done seen timeout");
    end_of_test();
  end
endmodule
